// ---- core/rpe_cfg.svh ----
`ifndef RPE_CFG_SVH
`define RPE_CFG_SVH
// Register addresses
`define RPE_ADDR_SEL 8'h4C
`define RPE_ADDR_FLAGS 8'h7A
`define RPE_ADDR_COUNT 8'h7B
`define RPE_ADDR_RAWCFG 8'h7C
// Reset values
`define RPE_RST_RAWCFG 8'h20
`define RPE_RST_FLAGS 4'h0
`define RPE_RST_COUNT 8'h00
`define RPE_RST_SEL 2'h0
// Error flag positions
`define RPE_FLG_LEN 3
`define RPE_FLG_CKSUM 2
`define RPE_FLG_ECC2 1
`define RPE_FLG_ECC1 0
// Raw config field positions
`define RPE_CFG_RED_HI 7
`define RPE_CFG_RED_LO 6
`define RPE_CFG_PAR 5
`define RPE_CFG_LINE 4
`define RPE_CFG_FRAME 3
`define RPE_CFG_AUTO 2
`define RPE_CFG_LVPOL 1
`define RPE_CFG_FVPOL 0
// Reduction codes
`define RPE_RED_UPPER 2'h2
`define RPE_RED_LOWER 2'h3
// Counter limit and packet class
`define RPE_CNT_MAX 8'hFF
`define RPE_LONG_DT 6'h10
// Header ECC parity masks
`define RPE_ECC_P0 24'hF12CB7
`define RPE_ECC_P1 24'hF2555B
`define RPE_ECC_P2 24'h749A6D
`define RPE_ECC_P3 24'hB8E38E
`define RPE_ECC_P4 24'hDF03F0
`define RPE_ECC_P5 24'hEFFC00
// Line and frame counter width
`define RPE_LEN_W 16
`endif

// ---- core/rpe_pkg.sv ----
`include "rpe_cfg.svh"
package rpe_pkg;
   // Polarity learning phases
   typedef enum logic [1:0] {
      rpe_pol_learn = 2'b00,
      rpe_pol_skip = 2'b01,
      rpe_pol_run = 2'b10
   } rpe_pol_t;
   // Raw path state
   typedef struct packed {
      rpe_pol_t pol;
      logic fv_act;
      logic lv_act;
      logic fv_d;
      logic lv_d;
      logic drop;
      logic hold;
      logic len_known;
      logic lines_known;
      logic [`RPE_LEN_W-1:0] pix_cnt;
      logic [`RPE_LEN_W-1:0] line_len;
      logic [`RPE_LEN_W-1:0] line_cnt;
      logic [`RPE_LEN_W-1:0] frame_lines;
      logic [1:0] pass_cnt;
      logic pass;
      logic vid_vld;
      logic [9:0] vid_data;
      logic vid_lv;
      logic vid_fv;
   } rpe_raw_st_t;
endpackage

// ---- core/rpe_raw_path.sv ----
`timescale 1ns/1ps
`default_nettype none
module rpe_raw_path import rpe_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Port configuration
   input wire logic [7:0] cfg,
   input wire logic [1:0] pass_thr,
   input wire logic rx_lock,
   // Raw video in
   input wire logic raw_vld,
   input wire logic [9:0] raw_data,
   input wire logic raw_lv,
   input wire logic raw_fv,
   input wire logic par_err,
   // Video out
   output logic vid_vld,
   output logic [9:0] vid_data,
   output logic vid_lv,
   output logic vid_fv,
   output logic pass
);
   rpe_raw_st_t q, d; // State and next state
   logic auto_m, fv_lvl, lv_lvl, fv_on, lv_on, pol_ok, fwd, par_hit;
   logic [1:0] red;

   // Next state of the raw path
   always_comb begin
      d = q;
      auto_m = cfg[`RPE_CFG_AUTO];
      red = cfg[`RPE_CFG_RED_HI:`RPE_CFG_RED_LO];
      // Active levels, learned or manual
      fv_lvl = auto_m ? q.fv_act : ~cfg[`RPE_CFG_FVPOL];
      lv_lvl = auto_m ? q.lv_act : ~cfg[`RPE_CFG_LVPOL];
      fv_on = (raw_fv == fv_lvl);
      lv_on = (raw_lv == lv_lvl);
      d.fv_d = fv_on;
      d.lv_d = lv_on;
      // Polarity learning
      if (!auto_m) begin
         d.pol = rpe_pol_learn;
      end else begin
         case (q.pol)
            rpe_pol_learn: begin
               // Levels seen beside a pixel are the active ones
               if (raw_vld) begin
                  d.fv_act = raw_fv;
                  d.lv_act = raw_lv;
                  d.pol = rpe_pol_skip;
               end
            end
            rpe_pol_skip: begin
               // Discard the frame in flight
               if (q.fv_d && !fv_on) begin
                  d.pol = rpe_pol_run;
               end
            end
            rpe_pol_run: d.pol = rpe_pol_run;
            default: d.pol = rpe_pol_learn;
         endcase
      end
      pol_ok = !auto_m || (q.pol == rpe_pol_run);
      // Frame start reopens forwarding
      if (fv_on && !q.fv_d) begin
         d.drop = 1'b0;
         d.line_cnt = '0;
      end
      // Pixel count within a line
      if (raw_vld && lv_on) begin
         d.pix_cnt = q.pix_cnt + 1'b1;
      end
      // Line end: compare against previous length
      if (q.lv_d && !lv_on) begin
         d.line_cnt = q.line_cnt + 1'b1;
         if (q.len_known && q.pix_cnt != q.line_len && cfg[`RPE_CFG_LINE]) begin
            d.drop = 1'b1;
         end
         d.line_len = q.pix_cnt;
         d.len_known = 1'b1;
         d.pix_cnt = '0;
      end
      // Frame end: compare lines per frame
      if (q.fv_d && !fv_on) begin
         if (q.lines_known && q.line_cnt != q.frame_lines && cfg[`RPE_CFG_FRAME]) begin
            d.hold = 1'b1;
            d.pass_cnt = '0;
         end else if (!q.drop && q.pass_cnt != 2'h3) begin
            d.pass_cnt = q.pass_cnt + 1'b1;
         end
         d.frame_lines = q.line_cnt;
         d.lines_known = 1'b1;
      end
      // Parity error ends the frame
      par_hit = par_err && cfg[`RPE_CFG_PAR];
      if (par_hit && fv_on) begin
         d.drop = 1'b1;
      end
      // Pass qualification
      if (!rx_lock) begin
         d.pass_cnt = '0;
      end
      d.pass = rx_lock && (pass_thr == 2'h0 || q.pass_cnt >= pass_thr);
      if (q.pass) begin
         d.hold = 1'b0;
      end
      // Forwarding and byte reduction
      fwd = pol_ok && !q.hold && !q.drop;
      d.vid_vld = raw_vld && fv_on && lv_on && fwd && !par_hit;
      d.vid_fv = fv_on && fwd;
      d.vid_lv = lv_on && fv_on && fwd;
      case (red)
         `RPE_RED_UPPER: d.vid_data = {2'h0, raw_data[9:2]};
         `RPE_RED_LOWER: d.vid_data = {2'h0, raw_data[7:0]};
         default: d.vid_data = raw_data;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign vid_vld = q.vid_vld;
   assign vid_data = q.vid_data;
   assign vid_lv = q.vid_lv;
   assign vid_fv = q.vid_fv;
   assign pass = q.pass;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // No video while polarity is still unknown
   property p_auto_drop;
      cfg[`RPE_CFG_AUTO] && q.pol != rpe_pol_run |=> !vid_vld;
   endproperty
   a_auto_drop: assert property (p_auto_drop) else $error("video during polarity learn");

   // Parity error in frame blocks the rest of it
   property p_par_trunc;
      par_err && cfg[`RPE_CFG_PAR] && fv_on && !(q.fv_d && !fv_on) ##1 fv_on[*2] |-> !vid_vld;
   endproperty
   a_par_trunc: assert property (p_par_trunc) else $error("frame not cut on parity");

   // Zero threshold passes on lock
   property p_pass_lock;
      rx_lock && pass_thr == 2'h0 |=> pass;
   endproperty
   a_pass_lock: assert property (p_pass_lock) else $error("no pass after lock");

   // Upper byte reduction
   property p_red_upper;
      cfg[`RPE_CFG_RED_HI:`RPE_CFG_RED_LO] == `RPE_RED_UPPER |=> vid_data == {2'h0, $past(raw_data[9:2])};
   endproperty
   a_red_upper: assert property (p_red_upper) else $error("upper reduction wrong");
endmodule
`default_nettype wire

// ---- core/rpe_port_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module rpe_port_regs import rpe_pkg::*; #(
   parameter int NP = 4 // Number of receive ports
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access from the I2C target
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Packet end reports from each receiver
   input wire logic [NP-1:0] pkt_end,
   input wire logic [NP-1:0][23:0] pkt_hdr,
   input wire logic [NP-1:0][5:0] pkt_ecc,
   input wire logic [NP-1:0][15:0] pkt_bytes,
   input wire logic [NP-1:0][15:0] pkt_crc_calc,
   input wire logic [NP-1:0][15:0] pkt_crc_rx,
   // Corrected header out
   output logic [NP-1:0][23:0] hdr_out,
   output logic [NP-1:0] hdr_out_vld,
   output logic [NP-1:0] hdr_out_bad,
   // Raw video in
   input wire logic [NP-1:0] raw_vld,
   input wire logic [NP-1:0][9:0] raw_data,
   input wire logic [NP-1:0] raw_lv,
   input wire logic [NP-1:0] raw_fv,
   input wire logic [NP-1:0] par_err,
   input wire logic [NP-1:0] rx_lock,
   input wire logic [NP-1:0][1:0] pass_thr,
   // Raw video out
   output logic [NP-1:0] vid_vld,
   output logic [NP-1:0][9:0] vid_data,
   output logic [NP-1:0] vid_lv,
   output logic [NP-1:0] vid_fv,
   output logic [NP-1:0] port_pass
);
   // Port count limited by the select field
   if (NP < 1 || NP > 4) begin : g_np_check
      $error("NP must be 1 to 4");
   end

   // Complete register state
   typedef struct packed {
      logic [NP-1:0][3:0] flg;
      logic [NP-1:0][7:0] cnt;
      logic [NP-1:0][7:0] cfg;
      logic [1:0] sel;
      logic [7:0] rdata;
      logic rvalid;
      logic [NP-1:0][23:0] hdr;
      logic [NP-1:0] hdr_vld;
      logic [NP-1:0] hdr_bad;
   } rpe_regs_t;

   rpe_regs_t q, d; // State and next state

   // Header ECC parity over 24 bits
   function automatic logic [5:0] ecc_calc(input logic [23:0] h);
      ecc_calc = {^(h & `RPE_ECC_P5), ^(h & `RPE_ECC_P4), ^(h & `RPE_ECC_P3),
                  ^(h & `RPE_ECC_P2), ^(h & `RPE_ECC_P1), ^(h & `RPE_ECC_P0)};
   endfunction

   // Decode syndrome: {multi, single, fixed header}
   function automatic logic [25:0] hdr_fix(input logic [23:0] h, input logic [5:0] syn);
      logic [23:0] fixed;
      logic hit;
      fixed = h;
      hit = 1'b0;
      // Data bit error: flip the matching column
      for (int j = 0; j < 24; j++) begin
         if (syn == ecc_calc(24'h000001 << j)) begin
            fixed[j] = ~h[j];
            hit = 1'b1;
         end
      end
      // Error in an ECC bit: header itself is good
      if ($onehot(syn)) begin
         hit = 1'b1;
      end
      hdr_fix = {(syn != 6'h00) && !hit, hit, fixed};
   endfunction

   // Port index match against the select field
   function automatic logic sel_is(input logic [1:0] sel, input int i);
      sel_is = (sel == i[1:0]);
   endfunction

   logic [NP-1:0][25:0] fix; // Decoded header per port
   logic [NP-1:0][3:0] ev; // Error events per port
   logic [NP-1:0] long_pkt; // Packet carries payload
   logic rd_flags, rd_count, wr_cfg;

   // Next state of registers and status
   always_comb begin
      d = q;
      fix = '0;
      ev = '0;
      long_pkt = '0;
      rd_flags = reg_rd && reg_addr == `RPE_ADDR_FLAGS;
      rd_count = reg_rd && reg_addr == `RPE_ADDR_COUNT;
      wr_cfg = reg_wr && reg_addr == `RPE_ADDR_RAWCFG;
      // Port select write
      if (reg_wr && reg_addr == `RPE_ADDR_SEL) begin
         d.sel = reg_wdata[1:0];
      end
      for (int i = 0; i < NP; i++) begin
         // Header check and correction
         fix[i] = hdr_fix(pkt_hdr[i], ecc_calc(pkt_hdr[i]) ^ pkt_ecc[i]);
         long_pkt[i] = fix[i][5:0] >= `RPE_LONG_DT;
         if (pkt_end[i]) begin
            ev[i][`RPE_FLG_ECC2] = fix[i][25];
            ev[i][`RPE_FLG_ECC1] = fix[i][24];
            // Word count from header against bytes seen
            ev[i][`RPE_FLG_LEN] = long_pkt[i] && !fix[i][25]
                                  && fix[i][23:8] != pkt_bytes[i];
            ev[i][`RPE_FLG_CKSUM] = long_pkt[i] && pkt_crc_calc[i] != pkt_crc_rx[i];
         end
         // Sticky flags, event wins over read clear
         if (rd_flags && sel_is(q.sel, i)) begin
            d.flg[i] = ev[i];
         end else begin
            d.flg[i] = q.flg[i] | ev[i];
         end
         // Errored packet tally
         if (rd_count && sel_is(q.sel, i)) begin
            d.cnt[i] = {7'h00, |ev[i]};
         end else if (|ev[i] && q.cnt[i] != `RPE_CNT_MAX) begin
            d.cnt[i] = q.cnt[i] + 8'h01;
         end
         // Raw configuration write
         if (wr_cfg && sel_is(q.sel, i)) begin
            d.cfg[i] = reg_wdata;
         end
         // Corrected header out, multi-bit left as is
         d.hdr_vld[i] = pkt_end[i];
         if (pkt_end[i]) begin
            d.hdr[i] = fix[i][25] ? pkt_hdr[i] : fix[i][23:0];
            d.hdr_bad[i] = fix[i][25];
         end
      end
      // Read data, selected port copy
      d.rvalid = reg_rd;
      d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `RPE_ADDR_SEL: d.rdata = {6'h00, q.sel};
            `RPE_ADDR_FLAGS: begin
               for (int i = 0; i < NP; i++) begin
                  if (sel_is(q.sel, i)) begin
                     d.rdata = {4'h0, q.flg[i]};
                  end
               end
            end
            `RPE_ADDR_COUNT: begin
               for (int i = 0; i < NP; i++) begin
                  if (sel_is(q.sel, i)) begin
                     d.rdata = q.cnt[i];
                  end
               end
            end
            `RPE_ADDR_RAWCFG: begin
               for (int i = 0; i < NP; i++) begin
                  if (sel_is(q.sel, i)) begin
                     d.rdata = q.cfg[i];
                  end
               end
            end
            default: d.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q.flg <= {NP{`RPE_RST_FLAGS}};
         q.cnt <= {NP{`RPE_RST_COUNT}};
         q.cfg <= {NP{`RPE_RST_RAWCFG}};
         q.sel <= `RPE_RST_SEL;
         q.rdata <= 8'h00;
         q.rvalid <= 1'b0;
         q.hdr <= '0;
         q.hdr_vld <= '0;
         q.hdr_bad <= '0;
      end else begin
         q <= d;
      end
   end

   // Register and header outputs
   assign reg_rdata = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign hdr_out = q.hdr;
   assign hdr_out_vld = q.hdr_vld;
   assign hdr_out_bad = q.hdr_bad;

   // One raw path per port
   for (genvar g = 0; g < NP; g++) begin : g_raw
      rpe_raw_path u_raw (
         .clk(clk),
         .rstn(rstn),
         .cfg(q.cfg[g]),
         .pass_thr(pass_thr[g]),
         .rx_lock(rx_lock[g]),
         .raw_vld(raw_vld[g]),
         .raw_data(raw_data[g]),
         .raw_lv(raw_lv[g]),
         .raw_fv(raw_fv[g]),
         .par_err(par_err[g]),
         .vid_vld(vid_vld[g]),
         .vid_data(vid_data[g]),
         .vid_lv(vid_lv[g]),
         .vid_fv(vid_fv[g]),
         .pass(port_pass[g])
      );
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Length mismatch on port 0 sets its flag
   property p_len_flag;
      pkt_end[0] && long_pkt[0] && !fix[0][25] && fix[0][23:8] != pkt_bytes[0]
         |=> q.flg[0][`RPE_FLG_LEN];
   endproperty
   a_len_flag: assert property (p_len_flag) else $error("length flag not set");

   // Checksum mismatch on port 0 sets its flag
   property p_ck_flag;
      pkt_end[0] && long_pkt[0] && pkt_crc_calc[0] != pkt_crc_rx[0]
         |=> q.flg[0][`RPE_FLG_CKSUM];
   endproperty
   a_ck_flag: assert property (p_ck_flag) else $error("checksum flag not set");

   // Multi-bit error flagged and header passed unchanged
   property p_ecc2;
      pkt_end[0] && fix[0][25]
         |=> q.flg[0][`RPE_FLG_ECC2] && hdr_out_bad[0] && hdr_out[0] == $past(pkt_hdr[0]);
   endproperty
   a_ecc2: assert property (p_ecc2) else $error("multi-bit ecc mishandled");

   // Single-bit error corrected and flagged
   property p_ecc1;
      pkt_end[0] && fix[0][24]
         |=> q.flg[0][`RPE_FLG_ECC1] && !hdr_out_bad[0]
             && ($countones(hdr_out[0] ^ $past(pkt_hdr[0]))
                + $countones(ecc_calc(hdr_out[0]) ^ $past(pkt_ecc[0]))) == 1;
   endproperty
   a_ecc1: assert property (p_ecc1) else $error("single-bit ecc mishandled");

   // Flag read returns old value then clears
   property p_flag_rc;
      rd_flags && q.sel == 2'h0 && !pkt_end[0]
         |=> reg_rvalid && reg_rdata == {4'h0, $past(q.flg[0])} && q.flg[0] == 4'h0;
   endproperty
   a_flag_rc: assert property (p_flag_rc) else $error("flag read clear wrong");

   // Event during counter read is kept
   property p_cnt_keep;
      rd_count && q.sel == 2'h0 && |ev[0] |=> q.cnt[0] == 8'h01;
   endproperty
   a_cnt_keep: assert property (p_cnt_keep) else $error("event lost on read");

   // Counter stays at its maximum
   property p_cnt_sat;
      q.cnt[0] == `RPE_CNT_MAX && !(rd_count && q.sel == 2'h0) |=> q.cnt[0] == `RPE_CNT_MAX;
   endproperty
   a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");

   // Counter steps once per errored packet
   property p_cnt_step;
      |ev[0] && q.cnt[0] < 8'h10 && !rd_count |=> q.cnt[0] == $past(q.cnt[0]) + 8'h01;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

   // Config write reaches port 0 when it is selected
   property p_sel_write;
      wr_cfg && q.sel == 2'h0 ##1 !wr_cfg[*2] |-> q.cfg[0] == $past(reg_wdata, 2);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("port select write wrong");
endmodule
`default_nettype wire

// ---- dv/rpe_cam_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Remote camera source for one port
module rpe_cam_model (
   // Clock
   input wire logic clk,
   // Raw video out
   output logic raw_vld,
   output logic [9:0] raw_data,
   output logic raw_lv,
   output logic raw_fv,
   output logic par_err
);
   initial begin
      raw_vld = 1'b0;
      raw_data = 10'h000;
      raw_lv = 1'b0;
      raw_fv = 1'b0;
      par_err = 1'b0;
   end
   // One frame; gaps carry inverted data, fault after pixel 0 of line pl
   task automatic frame(input int nl, input int len, input logic [9:0] b,
         input logic lvl, input logic fvl, input int pl);
      int n;
      n = 0;
      raw_lv = lvl; // Idle at inactive level
      raw_fv = fvl;
      repeat (2) @(posedge clk) #1;
      raw_fv = ~fvl;
      @(posedge clk) #1;
      for (int l = 0; l < nl; l++) begin
         raw_lv = ~lvl;
         for (int p = 0; p < len; p++) begin
            raw_vld = 1'b1;
            raw_data = b + 10'(n);
            n++;
            @(posedge clk) #1;
            raw_vld = 1'b0;
            raw_data = ~raw_data; // Stale data never repeats
            par_err = (l == pl && p == 0);
            @(posedge clk) #1;
            par_err = 1'b0;
         end
         raw_lv = lvl;
         repeat (2) @(posedge clk) #1;
      end
      raw_fv = fvl;
      repeat (4) @(posedge clk) #1;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rpe_cfg.svh"
module tb import rpe_pkg::*;;
   localparam int NP = 2;
   localparam logic [23:0] HD = 24'h00102B; // Long packet, 16 bytes
   localparam logic [7:0] FE [5] = '{8'h08, 8'h04, 8'h01, 8'h02, 8'h00};
   logic clk, rstn, reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
   logic [NP-1:0] pkt_end, hdr_out_vld, hdr_out_bad, rx_lock;
   logic [NP-1:0] vid_vld, vid_lv, vid_fv, port_pass;
   logic [NP-1:0][23:0] pkt_hdr, hdr_out;
   logic [NP-1:0][5:0] pkt_ecc;
   logic [NP-1:0][15:0] pkt_bytes, pkt_crc_calc, pkt_crc_rx;
   logic [NP-1:0][9:0] vid_data;
   logic [NP-1:0][1:0] pass_thr;
   wire logic [NP-1:0] raw_vld, raw_lv, raw_fv, par_err;
   wire logic [NP-1:0][9:0] raw_data;
   int err_total, checks_done, i, k;
   logic [15:0] rd_q[$], px_q[$]; // Expected reads and pixels
   // Clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // One camera per port
   for (genvar g = 0; g < NP; g++) begin : g_cam
      rpe_cam_model u_cam (.clk(clk), .raw_vld(raw_vld[g]), .raw_data(raw_data[g]),
         .raw_lv(raw_lv[g]), .raw_fv(raw_fv[g]), .par_err(par_err[g]));
   end
   rpe_port_regs #(.NP(NP)) u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pkt_end(pkt_end), .pkt_hdr(pkt_hdr), .pkt_ecc(pkt_ecc),
      .pkt_bytes(pkt_bytes), .pkt_crc_calc(pkt_crc_calc), .pkt_crc_rx(pkt_crc_rx),
      .hdr_out(hdr_out), .hdr_out_vld(hdr_out_vld), .hdr_out_bad(hdr_out_bad),
      .raw_vld(raw_vld), .raw_data(raw_data), .raw_lv(raw_lv), .raw_fv(raw_fv),
      .par_err(par_err), .rx_lock(rx_lock), .pass_thr(pass_thr), .vid_vld(vid_vld),
      .vid_data(vid_data), .vid_lv(vid_lv), .vid_fv(vid_fv), .port_pass(port_pass));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Monitor: every result takes the oldest note
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1)
         chk({8'h00, reg_rdata}, rd_q.size() ? rd_q.pop_front() : 16'hFFFF);
      if (vid_vld[0] === 1'b1)
         chk({4'h0, vid_fv[0], vid_lv[0], vid_data[0]}, px_q.size() ? px_q.pop_front() : 16'hFFFF);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk) #1;
      reg_wr = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back({8'h00, e});
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk) #1;
      reg_rd = 1'b0;
      @(posedge clk) #1;
   endtask
   function automatic logic [5:0] ecc(input logic [23:0] h);
      ecc = {^(h & `RPE_ECC_P5), ^(h & `RPE_ECC_P4), ^(h & `RPE_ECC_P3),
         ^(h & `RPE_ECC_P2), ^(h & `RPE_ECC_P1), ^(h & `RPE_ECC_P0)};
   endfunction
   // Packet report with header flips f; rdf reads flags in the same cycle
   task automatic pkt(input int p, input logic [23:0] f, input logic [15:0] nb,
         input logic [15:0] cr, input logic rdf);
      logic bad;
      bad = $countones(f) > 1;
      pkt_hdr[p] = HD ^ f;
      pkt_ecc[p] = ecc(HD);
      pkt_bytes[p] = nb;
      pkt_crc_calc[p] = cr;
      pkt_crc_rx[p] = 16'h1234;
      pkt_end[p] = 1'b1;
      if (rdf) begin
         rd_q.push_back(16'h0000);
         reg_addr = `RPE_ADDR_FLAGS;
         reg_rd = 1'b1;
      end
      @(posedge clk) #1;
      pkt_end[p] = 1'b0;
      reg_rd = 1'b0;
      chk(hdr_out[p][15:0], bad ? 16'(HD ^ f) : HD[15:0]);
      chk({14'h0, hdr_out_vld[p], hdr_out_bad[p]}, {14'h0, 1'b1, bad});
      @(posedge clk) #1;
   endtask
   // Queue expected pixels of one frame, then send it
   task automatic vid(input logic [7:0] cf, input logic [1:0] pol, input int nl,
         input logic [9:0] b, input int pl, input int nexp);
      logic [9:0] d;
      for (int n = 0; n < nexp; n++) begin
         d = b + 10'(n);
         px_q.push_back({6'h03, cf[7:6] == `RPE_RED_UPPER ? {2'h0, d[9:2]} :
            cf[7:6] == `RPE_RED_LOWER ? {2'h0, d[7:0]} : d});
      end
      g_cam[0].u_cam.frame(nl, 4, b, pol[1], pol[0], pl);
   endtask
   task automatic drain(input string s);
      for (int t = 0; t < 400 && (px_q.size() || rd_q.size()); t++) @(posedge clk) #1;
      if (px_q.size() || rd_q.size()) begin
         err_total++;
         finish_test();
      end
      $display("test %s done", s);
   endtask
   // Hang guard
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
   // Main sequence
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, pkt_end} = '0;
      {pkt_hdr, pkt_ecc, pkt_bytes, pkt_crc_calc, pkt_crc_rx, pass_thr} = '0;
      rx_lock = '1;
      err_total = 0;
      checks_done = 0;
      k = $urandom(30552);
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      for (i = 0; i < NP; i++) begin
         wr(`RPE_ADDR_SEL, 8'(i));
         rd(`RPE_ADDR_FLAGS, 8'h00);
         rd(`RPE_ADDR_COUNT, 8'h00);
         rd(`RPE_ADDR_RAWCFG, 8'h20);
      end
      chk({14'h0, port_pass}, 16'h0003);
      c = 8'($urandom);
      wr(`RPE_ADDR_RAWCFG, c);
      wr(`RPE_ADDR_COUNT, 8'h55); // Read-only, ignored
      rd(`RPE_ADDR_COUNT, 8'h00);
      rd(8'h7D, 8'h00); // Unmapped
      rd(`RPE_ADDR_RAWCFG, c);
      wr(`RPE_ADDR_SEL, 8'h03);
      rd(`RPE_ADDR_RAWCFG, 8'h00); // No such port
      wr(`RPE_ADDR_SEL, 8'h00);
      rd(`RPE_ADDR_RAWCFG, 8'h20);
      drain("registers");
      // Length, checksum, single, double, clean
      for (i = 0; i < 5; i++) begin
         pkt(0, i == 2 ? 24'h000200 : i == 3 ? 24'h001200 : 24'h0, i == 0 ? 16'd15 : 16'd16,
            i == 1 ? 16'h4321 : 16'h1234, 1'b0);
         rd(`RPE_ADDR_FLAGS, FE[i]);
         rd(`RPE_ADDR_FLAGS, 8'h00);
         rd(`RPE_ADDR_COUNT, i < 4 ? 8'h01 : 8'h00);
      end
      pkt(1, 24'h0, 16'd15, 16'h1234, 1'b0);
      rd(`RPE_ADDR_FLAGS, 8'h00);
      wr(`RPE_ADDR_SEL, 8'h01);
      rd(`RPE_ADDR_FLAGS, 8'h08);
      wr(`RPE_ADDR_SEL, 8'h00);
      for (i = 0; i < 260; i++) pkt(0, 24'h0, 16'd15, 16'h1234, 1'b0);
      rd(`RPE_ADDR_COUNT, 8'hFF);
      rd(`RPE_ADDR_FLAGS, 8'h08);
      pkt(0, 24'h0, 16'd16, 16'h4321, 1'b1);
      rd(`RPE_ADDR_FLAGS, 8'h04);
      rd(`RPE_ADDR_COUNT, 8'h01);
      drain("packets");
      // Every reduction code, every manual polarity pair
      for (i = 0; i < 4; i++) begin
         c = {i[1:0], 4'h8, i[0], i[1]};
         wr(`RPE_ADDR_RAWCFG, c);
         vid(c, c[1:0], 3, 10'(i * 100 + 3), -1, 12);
         drain("reduce");
      end
      wr(`RPE_ADDR_RAWCFG, 8'h20);
      vid(8'h20, 2'b00, 3, 10'h040, 1, 5);
      vid(8'h20, 2'b00, 3, 10'h080, -1, 12);
      wr(`RPE_ADDR_RAWCFG, 8'h00);
      vid(8'h00, 2'b00, 3, 10'h0C0, 1, 12);
      drain("parity");
      rstn = 1'b0;
      repeat (2) @(posedge clk) #1;
      rstn = 1'b1;
      wr(`RPE_ADDR_RAWCFG, 8'h24);
      g_cam[0].u_cam.frame(2, 4, 10'h100, 1'b1, 1'b1, -1);
      vid(8'h24, 2'b11, 2, 10'h155, -1, 8);
      drain("auto");
      finish_test();
   end
endmodule
`default_nettype wire
